/* File: src/diag_pkg.sv */
// Shared constants for the fault-code logger and blink display
`default_nettype none
package diag_pkg;
    // Clock rate and the millisecond tick derived from it
    localparam int CLK_HZ       = 40_000_000;
    localparam int MS_PER_S     = 1000;
    localparam int TICK_CYC     = CLK_HZ / MS_PER_S;
    // Code set: 15 codes, index 0 is the start code
    localparam int CODE_NUM     = 15;
    localparam logic [3:0] START_IDX = 4'h0;
    // Two BCD digits per code, index 0 in the low byte
    localparam logic [119:0] CODE_TABLE = {
        8'h55, 8'h53, 8'h52, 8'h45, 8'h44, 8'h43, 8'h42, 8'h35,
        8'h25, 8'h19, 8'h18, 8'h17, 8'h14, 8'h13, 8'h12};
    // Fault memory depth
    localparam int MAX_CODES    = 6;
    localparam logic [2:0] MAX_CODES_3 = 3'h6;
    // Service timing, in milliseconds, and the erase pair count
    localparam int ERASE_WIN_MS = 12500;
    localparam int MIN_HOLD_MS  = 1000;
    localparam int ERASE_PAIRS  = 3;
    localparam int DEB_MS       = 20;
    localparam int LONG_MS      = 1200;
    localparam int SHORT_MS     = 400;
    localparam int GAP_MS       = 1600;
    // Reset values
    localparam logic [2:0] HELD_RST = 3'h0;
    localparam logic [13:0] MS_RST  = 14'h0000;
    typedef enum logic [1:0] {M_NORMAL, M_DIAG, M_ERASE, M_CLEARED} mode_t;
    typedef enum logic [1:0] {B_IDLE, B_ON, B_OFF} blink_t;
endpackage
`default_nettype wire

/* File: src/code_blinker.sv */
// Flashes one two-digit code: long blinks for tens, short blinks for units
`default_nettype none
module code_blinker #(
    parameter int LONG_MS  = diag_pkg::LONG_MS,
    parameter int SHORT_MS = diag_pkg::SHORT_MS,
    parameter int GAP_MS   = diag_pkg::GAP_MS
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic [7:0] code_bcd,
    output logic            lamp,
    output logic            busy
);
    diag_pkg::blink_t state_q, state_d;
    logic        digit_q, digit_d;
    logic [3:0]  left_q, left_d;
    logic [11:0] t_q, t_d;
    logic [3:0]  units_q, units_d;
    logic [11:0] dur;

    // Period of the current phase; gap only after a digit's last blink
    always_comb begin
        if (state_q == diag_pkg::B_ON) begin
            dur = digit_q ? 12'(SHORT_MS) : 12'(LONG_MS);
        end else if (left_q == 4'h0) begin
            dur = 12'(GAP_MS);
        end else begin
            dur = 12'(SHORT_MS);
        end
    end

    always_comb begin
        state_d = state_q;
        digit_d = digit_q;
        left_d  = left_q;
        t_d     = t_q;
        units_d = units_q;
        if (start && state_q == diag_pkg::B_IDLE) begin
            state_d = diag_pkg::B_ON;
            digit_d = 1'b0;
            left_d  = code_bcd[7:4];
            units_d = code_bcd[3:0];
            t_d     = 12'h000;
        end else if (tick && state_q != diag_pkg::B_IDLE) begin
            if (t_q + 12'h001 >= dur) begin
                t_d = 12'h000;
                unique case (state_q)
                    diag_pkg::B_ON: begin
                        state_d = diag_pkg::B_OFF;
                        left_d  = left_q - 4'h1;
                    end
                    diag_pkg::B_OFF: begin
                        if (left_q != 4'h0) begin
                            state_d = diag_pkg::B_ON;
                        end else if (!digit_q) begin
                            state_d = diag_pkg::B_ON;
                            digit_d = 1'b1;
                            left_d  = units_q;
                        end else begin
                            state_d = diag_pkg::B_IDLE;
                        end
                    end
                    diag_pkg::B_IDLE: begin
                        state_d = diag_pkg::B_IDLE;
                    end
                endcase
            end else begin
                t_d = t_q + 12'h001;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= diag_pkg::B_IDLE;
            digit_q <= 1'b0;
            left_q  <= 4'h0;
            t_q     <= 12'h000;
            units_q <= 4'h0;
        end else begin
            state_q <= state_d;
            digit_q <= digit_d;
            left_q  <= left_d;
            t_q     <= t_d;
            units_q <= units_d;
        end
    end

    assign lamp = (state_q == diag_pkg::B_ON);
    assign busy = (state_q != diag_pkg::B_IDLE);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    blink_start_a: assert property (start && !busy |=> lamp && !digit_q)
        else $error("code display did not open with a tens blink");
    unit_after_a: assert property ($rose(digit_q) |-> lamp && left_q == units_q)
        else $error("units digit did not follow tens digit");
endmodule
`default_nettype wire

/* File: src/diag_logger.sv */
// Fault-code logger with blink-code self-diagnosis and timed erase
`default_nettype none
module diag_logger #(
    parameter int TICK_CYC = diag_pkg::TICK_CYC,
    parameter int LONG_MS  = diag_pkg::LONG_MS,
    parameter int SHORT_MS = diag_pkg::SHORT_MS,
    parameter int GAP_MS   = diag_pkg::GAP_MS,
    parameter int DEB_MS   = diag_pkg::DEB_MS
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       ign_on,
    input  wire logic       diag_term_n,
    input  wire logic       vehicle_moving,
    input  wire logic       fault_valid,
    input  wire logic [3:0] fault_idx,
    output logic            lamp_on,
    output logic            diag_active,
    output logic            erase_active,
    output logic [2:0]      codes_held,
    output logic            mem_full
);
    localparam int TW = $clog2(TICK_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and terminal debounce

    logic [TW-1:0] div_q, div_d;
    logic          tick_q, tick_d;
    logic          gnd_q, gnd_d;
    logic [7:0]    deb_q, deb_d;
    logic          ign_q;

    always_comb begin
        tick_d = (div_q == TW'(TICK_CYC - 1));
        div_d  = tick_d ? '0 : div_q + TW'(1);
        gnd_d  = gnd_q;
        deb_d  = 8'h00;
        if (!diag_term_n != gnd_q) begin
            deb_d = deb_q + {7'h00, tick_q};
            if (deb_q >= 8'(DEB_MS)) begin
                gnd_d = !diag_term_n;
                deb_d = 8'h00;
            end
        end
    end

    // Debounce registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
            gnd_q  <= 1'b0;
            deb_q  <= 8'h00;
            ign_q  <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
            gnd_q  <= gnd_d;
            deb_q  <= deb_d;
            ign_q  <= ign_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault memory; arst_n is the backup-supply power-on, not ignition

    logic [3:0] mem_q [diag_pkg::MAX_CODES];
    logic [3:0] mem_d [diag_pkg::MAX_CODES];
    logic [2:0] held_q, held_d;
    logic       erase_now;
    logic       rec_ok;

    assign rec_ok = fault_valid && fault_idx != diag_pkg::START_IDX
                    && fault_idx < 4'(diag_pkg::CODE_NUM);

    always_comb begin
        mem_d  = mem_q;
        held_d = held_q;
        if (erase_now) begin
            held_d = diag_pkg::HELD_RST;
        end else if (rec_ok && held_q < diag_pkg::MAX_CODES_3) begin
            mem_d[held_q] = fault_idx;
            held_d        = held_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        mem_q <= mem_d;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_q <= diag_pkg::HELD_RST;
        end else begin
            held_q <= held_d;
        end
    end

    assign codes_held = held_q;
    assign mem_full   = (held_q == diag_pkg::MAX_CODES_3);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode control: self-diagnosis, erase window, cleared

    diag_pkg::mode_t mode_q, mode_d;
    logic [13:0] ms_q, ms_d;
    logic [13:0] seg_q, seg_d;
    logic        rel_ok_q, rel_ok_d;
    logic        pair_ok_q, pair_ok_d;
    logic [1:0]  pairs_q, pairs_d;
    logic        win_done;

    assign win_done = (ms_q >= 14'(diag_pkg::ERASE_WIN_MS));

    always_comb begin
        mode_d    = mode_q;
        ms_d      = (tick_q && !win_done) ? ms_q + 14'h0001 : ms_q;
        seg_d     = (tick_q && seg_q != 14'h3FFF) ? seg_q + 14'h0001 : seg_q;
        rel_ok_d  = rel_ok_q;
        pair_ok_d = pair_ok_q;
        pairs_d   = pairs_q;
        erase_now = 1'b0;
        if (gnd_d != gnd_q) begin
            seg_d = diag_pkg::MS_RST;
        end
        unique case (mode_q)
            diag_pkg::M_NORMAL: begin
                // terminal already grounded at ignition on
                if (ign_on && !ign_q && gnd_q) begin
                    mode_d = diag_pkg::M_DIAG;
                    ms_d   = diag_pkg::MS_RST;
                end
            end
            diag_pkg::M_DIAG: begin
                if (vehicle_moving || (!gnd_q && win_done)) begin
                    mode_d = diag_pkg::M_NORMAL;
                end else if (!gnd_q) begin
                    mode_d    = diag_pkg::M_ERASE;
                    ms_d      = diag_pkg::MS_RST;
                    rel_ok_d  = 1'b0;
                    pair_ok_d = 1'b0;
                    pairs_d   = 2'h0;
                end
            end
            diag_pkg::M_ERASE: begin
                if (seg_q >= 14'(diag_pkg::MIN_HOLD_MS) && !gnd_q) begin
                    rel_ok_d = 1'b1;
                end
                if (gnd_d && !gnd_q) begin
                    pair_ok_d = rel_ok_q || seg_q >= 14'(diag_pkg::MIN_HOLD_MS);
                    rel_ok_d  = 1'b0;
                end
                if (!gnd_d && gnd_q) begin
                    if (pair_ok_q && seg_q >= 14'(diag_pkg::MIN_HOLD_MS)
                        && pairs_q != 2'(diag_pkg::ERASE_PAIRS)) begin
                        pairs_d = pairs_q + 2'h1;
                    end
                    pair_ok_d = 1'b0;
                end
                if (win_done) begin
                    mode_d = diag_pkg::M_NORMAL;
                end else if (pairs_q == 2'(diag_pkg::ERASE_PAIRS) && rel_ok_q) begin
                    erase_now = 1'b1;
                    mode_d    = diag_pkg::M_CLEARED;
                end
            end
            diag_pkg::M_CLEARED: begin
                mode_d = diag_pkg::M_CLEARED;
            end
        endcase
        if (!ign_on) begin
            mode_d = diag_pkg::M_NORMAL;
        end
    end

    // Mode registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q    <= diag_pkg::M_NORMAL;
            ms_q      <= diag_pkg::MS_RST;
            seg_q     <= diag_pkg::MS_RST;
            rel_ok_q  <= 1'b0;
            pair_ok_q <= 1'b0;
            pairs_q   <= 2'h0;
        end else begin
            mode_q    <= mode_d;
            ms_q      <= ms_d;
            seg_q     <= seg_d;
            rel_ok_q  <= rel_ok_d;
            pair_ok_q <= pair_ok_d;
            pairs_q   <= pairs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Display sequencer and lamp

    logic [2:0] slot_q, slot_d;
    logic       go_q, go_d;
    logic [3:0] sel_idx;
    logic [7:0] sel_bcd;
    logic       bl_lamp, bl_busy;
    logic       lamp_q, lamp_d;

    // slot 0 start, then newest first
    always_comb begin
        sel_idx = diag_pkg::START_IDX;
        if (slot_q != 3'h0 && slot_q <= held_q) begin
            sel_idx = mem_q[held_q - slot_q];
        end
        sel_bcd = diag_pkg::CODE_TABLE[{sel_idx, 3'h0} +: 8];
    end

    // advance and wrap to start code
    always_comb begin
        slot_d = slot_q;
        go_d   = 1'b0;
        if (mode_q != diag_pkg::M_DIAG) begin
            slot_d = 3'h0;
        end else if (!bl_busy && !go_q) begin
            go_d = 1'b1;
        end else if (go_q) begin
            slot_d = (slot_q >= held_q) ? 3'h0 : slot_q + 3'h1;
        end
    end

    always_comb begin
        unique case (mode_q)
            diag_pkg::M_NORMAL:  lamp_d = ign_on && (held_q != 3'h0 || rec_ok);
            diag_pkg::M_DIAG:    lamp_d = bl_lamp;
            diag_pkg::M_ERASE:   lamp_d = 1'b1;
            diag_pkg::M_CLEARED: lamp_d = 1'b1;
        endcase
    end

    // Sequencer and lamp registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_q <= 3'h0;
            go_q   <= 1'b0;
            lamp_q <= 1'b0;
        end else begin
            slot_q <= slot_d;
            go_q   <= go_d;
            lamp_q <= lamp_d;
        end
    end

    code_blinker #(
        .LONG_MS  (LONG_MS),
        .SHORT_MS (SHORT_MS),
        .GAP_MS   (GAP_MS)
    ) u_blink (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .tick     (tick_q),
        .start    (go_q),
        .code_bcd (sel_bcd),
        .lamp     (bl_lamp),
        .busy     (bl_busy)
    );

    assign lamp_on      = lamp_q;
    assign diag_active  = (mode_q == diag_pkg::M_DIAG);
    assign erase_active = (mode_q == diag_pkg::M_ERASE);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence early_release_s;
        mode_q == diag_pkg::M_DIAG && !gnd_q && !win_done && !vehicle_moving && ign_on;
    endsequence

    record_fault_a: assert property (rec_ok && held_q < 3'h6 ##0 !erase_now
        |=> held_q == $past(held_q) + 3'h1)
        else $error("fault was not recorded");
    mem_cap_a: assert property (held_q <= 3'h6)
        else $error("more than six codes held");
    full_hold_a: assert property (mem_full && !erase_now |=> mem_full)
        else $error("full memory changed without erase");
    start_only_a: assert property (held_q == 3'h0 |-> sel_bcd == 8'h12)
        else $error("empty memory did not show start code");
    release_erase_a: assert property (early_release_s |=> erase_active)
        else $error("release did not enter erase");
    erase_clear_a: assert property (erase_now |=> held_q == 3'h0 ##1 lamp_on)
        else $error("erase did not clear codes");
    erase_lamp_a: assert property (erase_active ##1 erase_active |-> lamp_on)
        else $error("lamp not lit during erase");
    motion_end_a: assert property (diag_active && vehicle_moving |=> !diag_active)
        else $error("motion did not end self-diagnosis");
    newest_first_a: assert property (slot_q == 3'h1 && held_q != 3'h0
        |-> sel_idx == mem_q[held_q - 3'h1])
        else $error("display did not start from newest code");
endmodule
`default_nettype wire

/* File: verification/tech_model.sv */
// Technician model that grounds and releases the diagnostic terminal
`default_nettype none
module tech_model #(
    parameter int HOLD_CYC = 2200
) (
    input  wire logic core_clk,
    input  wire logic want_gnd,
    output var logic  diag_term_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold_cnt = HOLD_CYC;
    // Released line rests high on its pull-up
    initial diag_term_n = 1'b1;
    // level held steady
    // A level stands at least a second; late requests just wait
    always @(posedge core_clk) begin
        if (hold_cnt < HOLD_CYC) begin
            hold_cnt <= hold_cnt + 1;
        end else if (want_gnd === diag_term_n) begin
            diag_term_n <= ~want_gnd;
            hold_cnt    <= 0;
        end
    end
endmodule
`default_nettype wire

/* File: verification/diag_logger_tb.sv */
// Self-checking bench for the fault-code logger and blink display
`default_nettype none
module diag_logger_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 2;  // Cycles per ms tick, keeps 12.5 s short
    logic       core_clk       = 1'b0;
    logic       arst_n         = 1'b0;
    logic       ign_on         = 1'b0;
    logic       vehicle_moving = 1'b0;
    logic       fault_valid    = 1'b0;
    logic [3:0] fault_idx      = 4'h0;
    logic       want_gnd       = 1'b0;
    logic       in_erase       = 1'b0;
    wire logic  diag_term_n;
    logic       lamp_on;
    logic       diag_active;
    logic       erase_active;
    logic       mem_full;
    logic [2:0] codes_held;
    int         error_cnt = 0;
    int         n_checks  = 0;
    int         lamp_bad  = 0;
    int         seed      = 32'hE29C79C3;
    int         base;
    int         t;
    int         tbl[15] = '{12, 13, 14, 17, 18, 19, 25, 35, 42, 43, 44, 45, 52, 53, 55};
    int         mq[$];  // Reference memory, newest first
    int         rd[$];

    always #12.5 core_clk = ~core_clk;

    diag_logger #(.TICK_CYC(TK), .LONG_MS(12), .SHORT_MS(4), .GAP_MS(16), .DEB_MS(20)) i_dut (
        .core_clk       (core_clk),
        .arst_n         (arst_n),
        .ign_on         (ign_on),
        .diag_term_n    (diag_term_n),
        .vehicle_moving (vehicle_moving),
        .fault_valid    (fault_valid),
        .fault_idx      (fault_idx),
        .lamp_on        (lamp_on),
        .diag_active    (diag_active),
        .erase_active   (erase_active),
        .codes_held     (codes_held),
        .mem_full       (mem_full)
    );
    tech_model #(.HOLD_CYC(1100 * TK)) i_tech (
        .core_clk    (core_clk),
        .want_gnd    (want_gnd),
        .diag_term_n (diag_term_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Lamp must stay lit while this flag is up
    always @(negedge core_clk) begin
        if (in_erase && lamp_on !== 1'b1) lamp_bad++;
    end

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", nm, ex, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Ask the technician for a level and wait until the line shows it
    task automatic term(input logic g);
        int w;
        w = 0;
        want_gnd = g;
        while (diag_term_n !== ~g && w < 3000) begin
            cyc(1);
            w++;
        end
    endtask

    // One digit: a run of blinks closed by a long dark gap
    task automatic blink_digit(output int cnt, output bit lng);
        int w, h, l;
        cnt = 0;
        do begin
            w = 0;
            h = 0;
            l = 0;
            while (lamp_on !== 1'b1 && w < 500) begin
                cyc(1);
                w++;
            end
            while (lamp_on === 1'b1 && h < 500) begin
                cyc(1);
                h++;
            end
            lng = (h > 8 * TK);
            cnt++;
            while (lamp_on !== 1'b1 && l <= 10 * TK) begin
                cyc(1);
                l++;
            end
        end while (l <= 10 * TK && cnt < 9);
    endtask

    // Decode codes; the first digit may be partial and is dropped
    task automatic read_codes(input int n);
        int c, d;
        bit lg;
        rd = {};
        blink_digit(c, lg);
        while (rd.size() < n) begin
            blink_digit(c, lg);
            if (lg) begin
                blink_digit(d, lg);
                rd.push_back(10 * c + d);
            end
        end
    endtask

    // Start code, stored codes newest first, then start code again
    task automatic check_display();
        int k, len;
        len = mq.size() + 1;
        read_codes(2 * len + 1);
        k = 0;
        while (k < len && rd[k] != 12) k++;
        for (int i = 0; i <= len; i++) begin
            chk("blink code", (i % len == 0) ? 12 : mq[i % len - 1], rd[k + i]);
        end
    endtask

    // Ground first, then ignition on, as a technician does
    task automatic enter_diag();
        ign_on = 1'b0;
        cyc(4);
        term(1'b1);
        cyc(30 * TK);
        ign_on = 1'b1;
        cyc(2);
        chk("diag_active", 1, diag_active);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(90000 * 25);
        error_cnt++;
        $display("[FAIL] watchdog expected end seen hang");
        test_done();
    end

    initial begin
        cyc(20);
        chk("held in reset", 0, codes_held);
        arst_n = 1'b1;
        ign_on = 1'b1;
        cyc(60);
        chk("lamp no fault", 0, lamp_on);
        // Back-to-back faults, two invalid indexes, two past full
        base = $unsigned($random(seed)) % 14;
        fault_valid = 1'b1;
        for (int i = 0; i < 10; i++) begin
            fault_idx = (i == 2) ? 4'h0 : (i == 5) ? 4'hF : 4'(1 + (base + i * 5) % 14);
            if (fault_idx inside {[1:14]} && mq.size() < 6) mq.push_front(tbl[fault_idx]);
            cyc(1);
            chk("codes_held", mq.size(), codes_held);
        end
        fault_valid = 1'b0;
        cyc(1);
        chk("mem_full", 1, mem_full);
        chk("lamp fault", 1, lamp_on);
        $display("test record done");
        ign_on = 1'b0;
        cyc(10);
        chk("held ign off", 6, codes_held);
        ign_on = 1'b1;
        cyc(10);
        chk("held ign on", 6, codes_held);
        $display("test retain done");
        enter_diag();
        check_display();
        term(1'b0);
        t = 0;
        while (erase_active !== 1'b1 && t < 100) begin
            cyc(1);
            t++;
        end
        chk("erase_active", 1, erase_active);
        cyc(2);
        in_erase = 1'b1;
        for (int i = 0; i < 3; i++) begin
            term(1'b1);
            term(1'b0);
        end
        t = 0;
        while (codes_held !== 3'h0 && t < 1200 * TK) begin
            cyc(1);
            t++;
        end
        mq = {};
        cyc(4);
        chk("held erased", 0, codes_held);
        chk("erase ended", 0, erase_active);
        chk("diag ended", 0, diag_active);
        // Any dark cycle counts, so a count past 255 cannot wrap to zero
        chk("lamp erase", 0, {7'h00, lamp_bad != 0});
        chk("lamp after", 1, lamp_on);
        in_erase = 1'b0;
        $display("test erase done");
        enter_diag();
        check_display();
        vehicle_moving = 1'b1;
        cyc(2);
        chk("diag motion", 0, diag_active);
        vehicle_moving = 1'b0;
        $display("test motion done");
        enter_diag();
        cyc(12600 * TK);
        term(1'b0);
        cyc(50 * TK);
        chk("late erase", 0, erase_active);
        chk("late diag", 0, diag_active);
        $display("test late release done");
        fault_idx = 4'h9;
        fault_valid = 1'b1;
        cyc(1);
        fault_valid = 1'b0;
        cyc(1);
        chk("held again", 1, codes_held);
        chk("lamp again", 1, lamp_on);
        $display("test record again done");
        test_done();
    end
endmodule
`default_nettype wire
